//--- verilog/nvm_pkg.sv
// Constants shared by the user nonvolatile byte-read memory.
package nvm_pkg;

    // ------------------------------------------------------------
    // Organisation
    // ------------------------------------------------------------
    localparam int BANK_COUNT = 8; // Number of banks.
    localparam int BANK_BITS = 128; // Bits held in one bank.
    localparam int BYTES_PER_BANK = BANK_BITS / 8; // Bytes in one bank.
    localparam int ADDR_WIDTH = 7; // Width of the fabric read address.
    localparam int BANK_SEL_WIDTH = 3; // Address bits that choose a bank.
    localparam int BYTE_SEL_WIDTH = 4; // Address bits that choose a byte.
    localparam int BYTE_SEL_LSB = 0; // Position of the byte field.
    localparam int BANK_SEL_LSB = 4; // Position of the bank field.
    localparam int TOTAL_BYTES = BANK_COUNT * BYTES_PER_BANK; // All bytes.

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] DATA_RESET = 8'h00; // Read data after reset.
    localparam logic [7:0] ERASED_BYTE = 8'hff; // Content of an erased byte.

    // ------------------------------------------------------------
    // Programming port commands
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PROG_IDLE,
        PROG_WRITE,
        PROG_ERASE,
        PROG_READ
    } prog_cmd_t;

endpackage : nvm_pkg

//--- verilog/user_nvm_byte_read_port.sv
// Byte-addressed user nonvolatile memory with fabric and programming ports.

// ----------------------------------------------------------------
// Module
// ----------------------------------------------------------------
// Operation
// - Eight banks of 128 bits each.
// - One byte per synchronous fabric read.
// - Top three address bits pick the bank.
// - Low four address bits pick the byte.
// - Only programming port writes or erases memory.
// - Programming port can also read contents back.
// - Loaded data optionally passes through decryption.
module user_nvm_byte_read_port #(
    parameter int BANKS = nvm_pkg::BANK_COUNT
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic rd_en,
    input wire logic [nvm_pkg::ADDR_WIDTH-1:0] rd_addr,
    output logic [7:0] rd_data,
    output logic rd_valid,
    input wire logic [1:0] prog_cmd,
    input wire logic [nvm_pkg::ADDR_WIDTH-1:0] prog_addr,
    input wire logic [7:0] prog_wdata,
    input wire logic prog_decrypt_en,
    input wire logic [7:0] prog_key,
    output logic [7:0] prog_rdata,
    output logic prog_rvalid
);
    import nvm_pkg::*;

    // Only the documented organisation is served by the address split,
    // so any other bank count is refused while the design is built.
    if (BANKS != BANK_COUNT) begin : g_bank_check
        $error("user_nvm_byte_read_port: BANKS must be 8");
    end

    // ------------------------------------------------------------
    // Storage and address decode
    // ------------------------------------------------------------

    // Forms the flat byte index from a bank number and byte number.
    // The bank number lands in the upper bits, so storage is bank major.
    function automatic logic [ADDR_WIDTH-1:0] byte_index(
        input logic [ADDR_WIDTH-1:0] addr
    );
        logic [BANK_SEL_WIDTH-1:0] bank;
        logic [BYTE_SEL_WIDTH-1:0] byte_pos;
        bank = addr[BANK_SEL_LSB +: BANK_SEL_WIDTH];
        byte_pos = addr[BYTE_SEL_LSB +: BYTE_SEL_WIDTH];
        return {bank, byte_pos};
    endfunction : byte_index

    // The memory array, eight banks of sixteen bytes, bank major.
    logic [7:0] mem_reg [TOTAL_BYTES];

    // Decoded indices for both ports.
    wire logic [ADDR_WIDTH-1:0] rd_index;
    wire logic [ADDR_WIDTH-1:0] prog_index;
    assign rd_index = byte_index(rd_addr);
    assign prog_index = byte_index(prog_addr);

    // Command decode on the programming port.
    wire logic prog_write;
    wire logic prog_erase;
    wire logic prog_read;
    assign prog_write = (prog_cmd == 2'(PROG_WRITE));
    assign prog_erase = (prog_cmd == 2'(PROG_ERASE));
    assign prog_read = (prog_cmd == 2'(PROG_READ));

    // Loaded byte, optionally descrambled by the key stream.
    wire logic [7:0] load_byte;
    assign load_byte = prog_decrypt_en ? (prog_wdata ^ prog_key)
                                       : prog_wdata;

    // ------------------------------------------------------------
    // Memory update: only the programming port alters contents
    // ------------------------------------------------------------

    // Writes one byte or erases the whole bank addressed.
    // The array has no reset, so stored bytes survive a reset of the port.
    // One command word names one action, so write and erase never meet.
    always_ff @(posedge clock) begin
        for (int i = 0; i < TOTAL_BYTES; i++) begin
            if (prog_erase && (i / BYTES_PER_BANK) ==
                int'(prog_index[ADDR_WIDTH-1:BYTE_SEL_WIDTH])) begin
                mem_reg[i] <= ERASED_BYTE;
            end else if (prog_write && i == int'(prog_index)) begin
                mem_reg[i] <= load_byte;
            end
        end
    end

    // ------------------------------------------------------------
    // Fabric read port
    // ------------------------------------------------------------

    // Samples the address and holds the byte until the next read.
    // The fabric only reads here; nothing on this side reaches the array.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= DATA_RESET;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            if (rd_en) begin
                rd_data <= mem_reg[rd_index];
            end
        end
    end

    // ------------------------------------------------------------
    // Programming port read-back
    // ------------------------------------------------------------

    // Returns one byte to the programming port a cycle after the command.
    // Read-back is a second read of the same array and never alters it.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prog_rdata <= DATA_RESET;
            prog_rvalid <= 1'b0;
        end else begin
            prog_rvalid <= prog_read;
            if (prog_read) begin
                prog_rdata <= mem_reg[prog_index];
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    // Every check below is switched off while reset is held.
    // Helper copy of the previous cycle's addressed byte.
    logic [7:0] seen_byte_reg;
    always_ff @(posedge clock) begin
        seen_byte_reg <= mem_reg[rd_index];
    end

    a_read_data_timing: assert property (
        @(posedge clock) disable iff (!rst_n)
        $past(rd_en) |-> rd_data == seen_byte_reg)
        else $error("Read byte does not match sampled address.");

    a_read_data_hold: assert property (
        @(posedge clock) disable iff (!rst_n)
        !rd_en |=> $stable(rd_data))
        else $error("Read byte changed without a read.");

    a_read_valid_pulse: assert property (
        @(posedge clock) disable iff (!rst_n)
        rd_en |=> rd_valid)
        else $error("Read valid missing after a read.");

    a_bank_decode_map: assert property (
        @(posedge clock) disable iff (!rst_n)
        rd_index[6:4] == rd_addr[6:4])
        else $error("Bank field decoded wrongly.");

    a_byte_decode_map: assert property (
        @(posedge clock) disable iff (!rst_n)
        rd_index[3:0] == rd_addr[3:0])
        else $error("Byte field decoded wrongly.");

    a_write_stores_byte: assert property (
        @(posedge clock) disable iff (!rst_n)
        prog_write |=> mem_reg[$past(prog_index)] == $past(load_byte))
        else $error("Programming write not stored.");

    a_erase_clears_bank: assert property (
        @(posedge clock) disable iff (!rst_n)
        prog_erase |=> mem_reg[{$past(prog_index[6:4]), 4'hf}] == 8'hff)
        else $error("Bank erase did not reach the last byte.");

    a_readback_timing: assert property (
        @(posedge clock) disable iff (!rst_n)
        prog_read && !prog_write |=>
            prog_rvalid && prog_rdata == mem_reg[$past(prog_index)])
        else $error("Programming read-back wrong.");

    a_decrypt_select: assert property (
        @(posedge clock) disable iff (!rst_n)
        prog_decrypt_en |-> load_byte == (prog_wdata ^ prog_key))
        else $error("Decryption path not applied.");

    a_plain_load_path: assert property (
        @(posedge clock) disable iff (!rst_n)
        !prog_decrypt_en |-> load_byte == prog_wdata)
        else $error("Plain load path altered the byte.");

    a_valid_drop_idle: assert property (
        @(posedge clock) disable iff (!rst_n)
        !rd_en |=> !rd_valid)
        else $error("Read valid raised without a read.");

    a_readback_valid_drop: assert property (
        @(posedge clock) disable iff (!rst_n)
        !prog_read |=> !prog_rvalid)
        else $error("Read-back valid raised without a read.");

    a_readback_data_hold: assert property (
        @(posedge clock) disable iff (!rst_n)
        !prog_read |=> $stable(prog_rdata))
        else $error("Read-back byte changed without a read.");

    a_erase_first_byte: assert property (
        @(posedge clock) disable iff (!rst_n)
        prog_erase |=>
            mem_reg[{$past(prog_index[6:4]), 4'h0}] == ERASED_BYTE)
        else $error("Bank erase did not reach the first byte.");

    a_fabric_no_write: assert property (
        @(posedge clock) disable iff (!rst_n)
        rd_en && !prog_write && !prog_erase |=>
            mem_reg[$past(rd_index)] == seen_byte_reg)
        else $error("Fabric read altered the stored byte.");

    a_read_flat_address: assert property (
        @(posedge clock) disable iff (!rst_n)
        rd_en && !prog_write && !prog_erase |=>
            rd_data == mem_reg[$past(rd_addr)])
        else $error("Read byte not taken from the addressed bank.");

endmodule : user_nvm_byte_read_port

//--- testbench/fabric_reader.sv
// Fabric-side reader model that fetches bytes from the user memory.
module fabric_reader (
    input wire logic clock,
    output logic rd_en,
    output logic [nvm_pkg::ADDR_WIDTH-1:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle with no request and a junk address.
    initial begin
        rd_en = 1'b0;
        rd_addr = 7'h55;
    end

    // Two reads back to back; v holds rd_valid over three edges.
    // A released address is inverted so stale values never match.
    task read2(input logic [6:0] a, input logic [6:0] b,
               output logic [7:0] d1, output logic [7:0] d2,
               output logic [2:0] v);
        @(posedge clock);
        #2 rd_en = 1'b1;
        rd_addr = a;
        @(posedge clock);
        #2 rd_addr = b;
        d1 = rd_data;
        v[2] = rd_valid;
        @(posedge clock);
        #2 rd_en = 1'b0;
        rd_addr = ~b;
        d2 = rd_data;
        v[1] = rd_valid;
        @(posedge clock);
        #2 v[0] = rd_valid;
    endtask : read2
endmodule : fabric_reader

//--- testbench/user_nvm_byte_read_port_bench.sv
// Self-checking bench for the user nonvolatile byte-read memory.
module user_nvm_byte_read_port_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import nvm_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic rd_en;
    logic [6:0] rd_addr;
    logic [7:0] rd_data, prog_wdata, prog_key, prog_rdata, d1, d2;
    logic rd_valid, prog_rvalid, prog_decrypt_en = 1'b0;
    logic [1:0] prog_cmd = 2'h0;
    logic [6:0] prog_addr = 7'h00;
    logic [2:0] v;
    int fail_count = 0;
    int compares = 0;

    // The clock runs at 20 MHz.
    always #25 clock = ~clock;

    user_nvm_byte_read_port i_dut (.clock(clock), .rst_n(rst_n),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_valid(rd_valid), .prog_cmd(prog_cmd), .prog_addr(prog_addr),
        .prog_wdata(prog_wdata), .prog_decrypt_en(prog_decrypt_en),
        .prog_key(prog_key), .prog_rdata(prog_rdata),
        .prog_rvalid(prog_rvalid));

    fabric_reader i_reader (.clock(clock), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));

    // Compares a data byte.
    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Compares a pattern of valid flags.
    task chkv(input logic [2:0] got, input logic [2:0] exp);
        chk({5'h00, got}, {5'h00, exp});
    endtask : chkv

    // Prints the verdict and ends the run.
    task end_sim;
        if (fail_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    // One programming command; a read answer is ready on return.
    task prog(input logic [1:0] c, input logic [6:0] a, input logic [7:0] d,
              input logic x);
        @(posedge clock);
        #2 prog_cmd = c;
        prog_addr = a;
        prog_wdata = d;
        prog_decrypt_en = x;
        @(posedge clock);
        #2 prog_cmd = 2'h0;
        prog_addr = ~a;
        prog_wdata = ~d;
    endtask : prog

    // Expected content written at a given bank.
    function automatic logic [7:0] pat(input int b);
        return 8'(b * BYTES_PER_BANK + 15 - b) ^ 8'ha5;
    endfunction : pat

    // Erases every bank, loads one byte per bank, odd banks decrypted.
    task t_load;
        for (int b = 0; b < BANK_COUNT; b++)
            prog(2'h2, 7'(b * BYTES_PER_BANK), 8'h00, 1'b0);
        for (int b = 0; b < BANK_COUNT; b++) begin
            prog(2'h1, 7'(b * BYTES_PER_BANK + 15 - b),
                 pat(b) ^ (b % 2 ? prog_key : 8'h00), 1'(b % 2));
            prog(2'h3, 7'(b * BYTES_PER_BANK + 15 - b), 8'h00, 1'b0);
            chkv({2'h0, prog_rvalid}, 3'h1);
            chk(prog_rdata, pat(b));
        end
    endtask : t_load

    // Back-to-back fabric reads of a loaded and an erased byte per bank.
    task t_fabric;
        for (int b = 0; b < BANK_COUNT; b++) begin
            i_reader.read2(7'(b * BYTES_PER_BANK + 15 - b),
                           7'(b * BYTES_PER_BANK), d1, d2, v);
            chkv(v, 3'h6);
            chk(d1, pat(b));
            chk(d2, ERASED_BYTE);
        end
    endtask : t_fabric

    // Erasing bank 3 clears its loaded byte; fabric reads see it.
    task t_erase;
        prog(2'h2, 7'h3c, 8'h00, 1'b0);
        i_reader.read2(7'h3c, 7'h4b, d1, d2, v);
        chk(d1, ERASED_BYTE);
        chk(d2, pat(4));
    endtask : t_erase

    // A reset in mid-run clears both answers but keeps the stored bytes.
    task t_reset;
        @(posedge clock);
        #2 rst_n = 1'b0;
        @(posedge clock);
        #2 chk(rd_data, DATA_RESET);
        chk(prog_rdata, DATA_RESET);
        chkv({1'b0, rd_valid, prog_rvalid}, 3'h0);
        rst_n = 1'b1;
        i_reader.read2(7'h4b, 7'h3c, d1, d2, v);
        chkv(v, 3'h6);
        chk(d1, pat(4));
        chk(d2, ERASED_BYTE);
    endtask : t_reset

    // Reset, then the scenarios in order.
    initial begin
        prog_key = 8'h3c;
        prog_wdata = 8'h00;
        repeat (16) @(posedge clock);
        chk(rd_data, DATA_RESET);
        chkv({1'b0, rd_valid, prog_rvalid}, 3'h0);
        #2 rst_n = 1'b1;
        t_load();
        t_fabric();
        t_erase();
        t_reset();
        end_sim();
    end

    // Cuts a hang short.
    initial begin
        #100000;
        fail_count++;
        end_sim();
    end
endmodule : user_nvm_byte_read_port_bench
